// ---- supervisor_defines.vh ----
// Constants for the supply supervisor, reset stretcher and watchdog.
// Assumes a 40 MHz system clock; included by supervisor.v.
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH

`define CLK_HZ            40000000
// Internal time base tick rate in Hz.
`define TICK_HZ           30000
`define TICK_DIV          (`CLK_HZ / `TICK_HZ)
// Reset pulse width, internal base: 100 ms typical, 50 ms least.
`define RST_MS            100
`define RST_INT_TICKS     ((`RST_MS * `TICK_HZ + 999) / 1000)
// External clock counts.
`define RST_EXT_CLKS      641
`define WD_FIRST_EXT_CLKS 20480
`define WD_EXT_CLKS       5120
// Internal watchdog periods in ms.
`define WD_FIRST_MS       2700
`define WD_FIRST_INT_TICKS ((`WD_FIRST_MS * `TICK_HZ) / 1000)
`define WD_INT_MS         170
`define WD_INT_TICKS      ((`WD_INT_MS * `TICK_HZ) / 1000)
// Early warning qualification samples.
`define NMI_SAMPLES       3
// Pushbutton debounce ticks.
`define PB_TICKS          600
// Strobe open detect: ticks without a low level.
`define OPEN_TICKS        24'h3FFFFF

`endif

// ---- supervisor.v ----
// Supply supervisor: reset generation, watchdog, early warning, SRAM gate.
// Assumes comparator results arrive as digital levels from analog logic.
// Overview of operation
// - Supply low drives the threshold flag and both resets active.
// - The threshold flag clears as soon as supply low clears.
// - Resets stay active at least 50 ms, nominally 100 ms, afterwards.
// - A falling strobe edge restarts the watchdog count from zero.
// - A watchdog expiry forces both reset outputs active.
// - The watchdog status output goes low once a timeout has occurred.
// - A debounced pushbutton press on the button input requests a reset.
// - The select input picks internal or external time base.
// - Supply out of tolerance raises the power fail flag with reset.
// - Supply out of tolerance holds the SRAM enable inactive.
// - An SRAM cycle in progress at supply fail completes first.
// - Early warning below threshold drives the interrupt low.
// - Watchdog status holds until a strobe edge or open strobe; supply low forces it low.
// - The watchdog counts only while both resets are inactive.
// - The interrupt needs three consecutive low samples at 30 kHz.
`include "supervisor_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module supervisor #(
    parameter WD_FIRST_INT = `WD_FIRST_INT_TICKS,
    parameter WD_INT       = `WD_INT_TICKS,
    parameter RST_INT      = `RST_INT_TICKS,
    parameter PB_TICKS     = `PB_TICKS,
    parameter OPEN_TICKS   = `OPEN_TICKS
) (
    // Clock and reset.
    input  wire clock_i,
    input  wire nrst_i,
    // Comparator results.
    input  wire supply_low_i,
    input  wire early_warn_low_i,
    // Time base.
    input  wire timebase_clock_input_i,
    input  wire timebase_select_i,
    // Watchdog and pushbutton.
    input  wire watchdog_kick_n_i,
    input  wire watchdog_kick_open_i,
    input  wire button_n_i,
    // SRAM enable.
    input  wire sram_enable_in_n_i,
    // Outputs.
    output reg  reset_o,
    output reg  reset_n_o,
    output reg  reset_threshold_flag_n_o,
    output reg  power_fail_flag_o,
    output reg  nmi_n_o,
    output reg  watchdog_tripped_n_o,
    output reg  sram_enable_out_n_o
);

    reg  [1:0]  low_sync_r;
    reg  [1:0]  warn_sync_r;
    reg  [1:0]  osc_sync_r;
    reg  [1:0]  kick_sync_r;
    reg  [1:0]  btn_sync_r;
    reg  [1:0]  ce_sync_r;
    reg         osc_d_r;
    reg         kick_d_r;
    reg  [15:0] div_r;
    reg         int_tick_r;
    reg  [23:0] rst_cnt_r;
    reg  [23:0] wd_cnt_r;
    reg  [23:0] open_cnt_r;
    reg  [15:0] pb_cnt_r;
    reg  [1:0]  nmi_cnt_r;
    reg         rst_act_r;
    reg         first_r;
    reg         wd_trip_r;
    reg         pb_press_r;
    reg         protect_r;
    wire        tick;
    wire        kick_fall;
    wire        kick_open;
    wire        supply_low;
    wire [23:0] rst_len;
    wire [23:0] wd_len;
    wire        rst_req;

    assign supply_low = low_sync_r[1];
    // External edge or internal divider tick as the time base
    assign tick = timebase_select_i ? int_tick_r
                                    : (osc_sync_r[1] & ~osc_d_r);
    assign rst_len = timebase_select_i ? RST_INT[23:0]
                                       : 24'd`RST_EXT_CLKS;
    assign wd_len = timebase_select_i ?
                    (first_r ? WD_FIRST_INT[23:0] : WD_INT[23:0]) :
                    (first_r ? 24'd`WD_FIRST_EXT_CLKS : 24'd`WD_EXT_CLKS);
    assign kick_fall = kick_d_r & ~kick_sync_r[1];
    assign kick_open = (open_cnt_r >= OPEN_TICKS[23:0]) |
                       watchdog_kick_open_i;
    assign rst_req = supply_low | pb_press_r;

    // Two-stage synchronisers
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_sync_r  <= 2'h3;
            warn_sync_r <= 2'h0;
            osc_sync_r  <= 2'h0;
            kick_sync_r <= 2'h3;
            btn_sync_r  <= 2'h3;
            ce_sync_r   <= 2'h3;
            osc_d_r     <= 1'b0;
            kick_d_r    <= 1'b1;
        end else begin
            low_sync_r  <= {low_sync_r[0], supply_low_i};
            warn_sync_r <= {warn_sync_r[0], early_warn_low_i};
            osc_sync_r  <= {osc_sync_r[0], timebase_clock_input_i};
            kick_sync_r <= {kick_sync_r[0], watchdog_kick_n_i};
            btn_sync_r  <= {btn_sync_r[0], button_n_i};
            ce_sync_r   <= {ce_sync_r[0], sram_enable_in_n_i};
            osc_d_r     <= osc_sync_r[1];
            kick_d_r    <= kick_sync_r[1];
        end
    end

    // Internal oscillator divider.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r      <= 16'h0000;
            int_tick_r <= 1'b0;
        end else if (div_r == `TICK_DIV - 1) begin
            div_r      <= 16'h0000;
            int_tick_r <= 1'b1;
        end else begin
            div_r      <= div_r + 16'h0001;
            int_tick_r <= 1'b0;
        end
    end

    // Pushbutton debounce and open strobe detection.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pb_cnt_r   <= 16'h0000;
            pb_press_r <= 1'b0;
            open_cnt_r <= 24'h000000;
        end else begin
            if (btn_sync_r[1]) begin
                pb_cnt_r   <= 16'h0000;
                pb_press_r <= 1'b0;
            end else if (pb_cnt_r >= PB_TICKS[15:0]) begin
                pb_press_r <= 1'b1;
            end else if (tick) begin
                pb_cnt_r <= pb_cnt_r + 16'h0001;
            end
            if (!kick_sync_r[1]) begin
                open_cnt_r <= 24'h000000;
            end else if (tick && !kick_open) begin
                open_cnt_r <= open_cnt_r + 24'h000001;
            end
        end
    end

    // Reset stretcher and watchdog.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_act_r <= 1'b1;
            rst_cnt_r <= 24'h000000;
            wd_cnt_r  <= 24'h000000;
            first_r   <= 1'b1;
            wd_trip_r <= 1'b0;
        end else begin
            if (rst_req) begin
                rst_act_r <= 1'b1; // and
                rst_cnt_r <= 24'h000000;
                first_r   <= 1'b1;
            end else if (rst_act_r) begin
                if (rst_cnt_r >= rst_len) begin
                    rst_act_r <= 1'b0;
                end else if (tick) begin
                    rst_cnt_r <= rst_cnt_r + 24'h000001;
                end
            end
            if (rst_act_r || rst_req || kick_open || kick_fall) begin
                wd_cnt_r <= 24'h000000; // and
            end else if (wd_cnt_r >= wd_len) begin
                wd_cnt_r  <= 24'h000000;
                rst_act_r <= 1'b1;
                rst_cnt_r <= 24'h000000;
                first_r   <= 1'b0;
                wd_trip_r <= 1'b1;
            end else if (tick) begin
                wd_cnt_r <= wd_cnt_r + 24'h000001;
            end
            if (kick_fall || kick_open) begin
                wd_trip_r <= 1'b0;
            end
        end
    end

    // Early warning qualification
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nmi_cnt_r <= 2'h0;
        end else if (int_tick_r) begin
            if (!warn_sync_r[1]) begin
                nmi_cnt_r <= 2'h0;
            end else if (nmi_cnt_r != `NMI_SAMPLES) begin
                nmi_cnt_r <= nmi_cnt_r + 2'h1;
            end
        end
    end

    // SRAM write protection.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            protect_r <= 1'b1;
        end else if (!supply_low) begin
            protect_r <= 1'b0;
        end else if (ce_sync_r[1]) begin
            protect_r <= 1'b1;
        end
    end

    // Registered outputs.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reset_o                  <= 1'b1;
            reset_n_o                <= 1'b0;
            reset_threshold_flag_n_o <= 1'b0;
            power_fail_flag_o        <= 1'b1;
            nmi_n_o                  <= 1'b1;
            watchdog_tripped_n_o     <= 1'b1;
            sram_enable_out_n_o      <= 1'b1;
        end else begin
            reset_o                  <= rst_act_r | rst_req;
            reset_n_o                <= ~(rst_act_r | rst_req);
            reset_threshold_flag_n_o <= ~supply_low;
            power_fail_flag_o        <= supply_low;
            nmi_n_o <= ~(nmi_cnt_r == `NMI_SAMPLES);
            watchdog_tripped_n_o     <= ~(wd_trip_r | supply_low);
            // Gate inactive when protected, else follow
            sram_enable_out_n_o <= protect_r | ce_sync_r[1];
        end
    end

endmodule
`default_nettype wire

// ---- supervisor_properties.sv ----
// Concurrent checks on the supervisor ports.
// Assumes a 40 MHz clock and an internal tick of 1333 clocks.
`timescale 1ns/10ps
`default_nettype none
module supervisor_properties (
    input wire logic clock_i, nrst_i, supply_low_i, early_warn_low_i,
    input wire logic timebase_clock_input_i, timebase_select_i,
    input wire logic watchdog_kick_n_i, watchdog_kick_open_i, button_n_i,
    input wire logic sram_enable_in_n_i, reset_o, reset_n_o,
    input wire logic reset_threshold_flag_n_o, power_fail_flag_o, nmi_n_o,
    input wire logic watchdog_tripped_n_o, sram_enable_out_n_o
);
    logic [15:0] warn_r;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) warn_r <= 16'h0000;
        else if (!early_warn_low_i) warn_r <= 16'h0000;
        else if (warn_r != 16'hFFFF) warn_r <= warn_r + 16'h0001;
    end
    // Clocks since the supply was last low and since warning last fell.
    logic [15:0] ok_r, calm_r;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ok_r   <= 16'h0000;
            calm_r <= 16'h0000;
        end else begin
            if (supply_low_i) ok_r <= 16'h0000;
            else if (ok_r != 16'hFFFF) ok_r <= ok_r + 16'h0001;
            if (early_warn_low_i) calm_r <= 16'h0000;
            else if (calm_r != 16'hFFFF) calm_r <= calm_r + 16'h0001;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    a_low_resets: assert property (supply_low_i[*5] |-> reset_o
        && !reset_n_o && !reset_threshold_flag_n_o) else $error("reset");
    a_flag_clears: assert property (!supply_low_i[*5] |->
        reset_threshold_flag_n_o) else $error("flag");
    a_reset_pair: assert property (reset_o != reset_n_o)
        else $error("pair");
    a_pf_follows: assert property (supply_low_i[*5] |->
        power_fail_flag_o) else $error("pf");
    a_sram_gated: assert property ((supply_low_i &&
        sram_enable_in_n_i)[*5] |-> sram_enable_out_n_o) else $error("gate");
    a_sram_follows: assert property ((!supply_low_i &&
        !sram_enable_in_n_i)[*5] |-> !sram_enable_out_n_o) else $error("ce");
    a_cycle_finishes: assert property ((!sram_enable_in_n_i[*4]
        ##0 !sram_enable_out_n_o) |=> !sram_enable_out_n_o) else $error("cyc");
    a_wdt_low_supply: assert property (supply_low_i[*5] |->
        !watchdog_tripped_n_o) else $error("wdt");
    a_nmi_qualified: assert property ($fell(nmi_n_o) |->
        warn_r >= 16'h0A6A) else $error("nmi early");
    a_nmi_release: assert property (calm_r >= 16'h0540 |->
        nmi_n_o) else $error("nmi");
    a_stretch_min: assert property ($fell(reset_o) |->
        ok_r >= 16'h0A6A) else $error("stretch");
endmodule
bind supervisor supervisor_properties u_props (.*);
`default_nettype wire

// ---- proc_model.sv ----
// Processor model that strobes the watchdog every 2000 clocks.
// Assumes the spacing sits well inside the shortest watchdog period.
`timescale 1ns/10ps
`default_nettype none
module proc_model (
    input  wire logic clock_i,
    input  wire logic kick_en_i,
    output var  logic kick_n_o
);
    logic [11:0] gap_r = 12'h000;
    initial kick_n_o = 1'b1;
    always @(posedge clock_i) begin
        gap_r <= #1 (gap_r == 12'h7CF) ? 12'h000 : gap_r + 12'h001;
        kick_n_o <= #1 !(kick_en_i && gap_r < 12'h008);
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the supervisor with shortened periods.
// Assumes the internal time base; the external one stays idle.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int TK = 1333;
    logic clk = 1'b0, nrst = 1'b0, low = 1'b1, warn = 1'b0, btn_n = 1'b1;
    logic ce_n = 1'b1, kick_en = 1'b0;
    logic osc_in = 1'b0, osc_sel = 1'b1, kick_open = 1'b0;
    wire logic kick_n, rst, rst_n, flag_n, pf, nmi_n, wdt_n, ceo_n;
    int n_errors = 0, cmp_count = 0, n;
    always #12.5 clk = ~clk;
    proc_model cpu (.clock_i(clk), .kick_en_i(kick_en), .kick_n_o(kick_n));
    supervisor #(.WD_FIRST_INT(8), .WD_INT(4), .RST_INT(3), .PB_TICKS(3),
        .OPEN_TICKS(50)) dut (.clock_i(clk), .nrst_i(nrst),
        .supply_low_i(low), .early_warn_low_i(warn),
        .timebase_clock_input_i(osc_in), .timebase_select_i(osc_sel),
        .watchdog_kick_n_i(kick_n), .watchdog_kick_open_i(kick_open),
        .button_n_i(btn_n), .sram_enable_in_n_i(ce_n), .reset_o(rst),
        .reset_n_o(rst_n), .reset_threshold_flag_n_o(flag_n),
        .power_fail_flag_o(pf), .nmi_n_o(nmi_n),
        .watchdog_tripped_n_o(wdt_n), .sram_enable_out_n_o(ceo_n));
    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task wait_rst(input logic v, input int lim);
        n = 0;
        while (rst_n !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task t_power_up;
        chk("flag_n", 1'b0, flag_n);
        chk("pf", 1'b1, pf);
        low = 1'b0;
        step(6);
        chk("flag_n", 1'b1, flag_n);
        chk("rst", 1'b1, rst);
        wait_rst(1'b1, 5 * TK);
        chk("stretch", 1'b1, n >= 2 * TK && n <= 4 * TK + 10);
    endtask
    task t_watchdog;
        step(10 * TK);
        chk("kicked", 1'b1, rst_n & wdt_n);
        kick_en = 1'b0;
        wait_rst(1'b0, 6 * TK);
        chk("trip", 1'b0, rst_n);
        chk("wdt_n", 1'b0, wdt_n);
        wait_rst(1'b1, 5 * TK);
        chk("wdt_n held", 1'b0, wdt_n);
        kick_en = 1'b1;
        step(2100);
        chk("wdt_n clear", 1'b1, wdt_n);
    endtask
    task t_open;
        kick_en = 1'b0;
        wait_rst(1'b0, 6 * TK);
        kick_open = 1'b1;
        step(6);
        chk("wdt_n open", 1'b1, wdt_n);
        wait_rst(1'b1, 5 * TK);
        step(5 * TK);
        chk("open idle", 1'b1, rst_n);
        kick_open = 1'b0;
        kick_en = 1'b1;
        step(20);
    endtask
    task t_button;
        btn_n = 1'b0;
        step(20);
        btn_n = 1'b1;
        step(5 * TK);
        chk("bounce", 1'b1, rst_n);
        btn_n = 1'b0;
        wait_rst(1'b0, 6 * TK);
        btn_n = 1'b1;
        chk("press", 1'b0, rst_n);
        wait_rst(1'b1, 5 * TK);
    endtask
    task t_sram;
        ce_n = 1'b0;
        step(6);
        chk("ce follow", 1'b0, ceo_n);
        low = 1'b1;
        step(6);
        chk("ce cycle", 1'b0, ceo_n);
        ce_n = 1'b1;
        step(6);
        ce_n = 1'b0;
        step(6);
        chk("ce gated", 1'b1, ceo_n);
        ce_n = 1'b1;
        low = 1'b0;
        wait_rst(1'b1, 5 * TK);
    endtask
    task t_nmi;
        warn = 1'b1;
        step(TK);
        chk("nmi early", 1'b1, nmi_n);
        step(3 * TK);
        chk("nmi", 1'b0, nmi_n);
        warn = 1'b0;
        step(2 * TK);
        chk("nmi off", 1'b1, nmi_n);
    endtask
    task final_report;
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        step(16);
        nrst = 1'b1;
        step(6);
        t_power_up;
        kick_en = 1'b1;
        t_watchdog;
        t_open;
        t_button;
        t_sram;
        t_nmi;
        final_report;
    end
    initial begin
        repeat (74 * TK) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire
